// ---- rtl/gfll_ctrl.sv ----
// GPS-disciplined frequency-locked loop controller with LED and registers.
//
// Contract
// RULE1 - Count oscillator over 16 s, repeat continuously.
// RULE2 - In-limit samples accumulate; others discarded, restart.
// RULE3 - At average count, adjust DAC from error.
// RULE4 - After DAC change, settle 16 seconds.
// RULE5 - Unlocked to Locked when average within limit.
// RULE6 - Holdover to Locked on one good sample.
// RULE7 - Locked to Holdover beyond holdover limit.
// RULE8 - Holdover keeps last DAC value.
// RULE9 - Holdover counter at limit gives Unlocked.
// RULE10 - Disable command stops tuning, keeps DAC.
// RULE11 - Tune command loads DAC while disabled.
// RULE12 - Enable command from Disabled gives Unlocked.
// RULE13 - LED steady colour follows state.
// RULE14 - Sticky alarm flashes red until cleared.
// RULE15 - One flash per pulse; none without pulses.
// RULE16 - Unlocked flashes off; no alarm flashes off.
// RULE17 - Receiver gives rising-edge one-second pulse.
// RULE18 - Report status and parameter records.
// RULE19 - Nominal count 160,000,000 over 16 pulses.
// RULE20 - Inhibit option disables outputs when Unlocked.
// RULE21 - Compare absolute difference from nominal.
// RULE22 - Holdover counter clears on holdover entry.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
module gfll_ctrl (
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        pps_in,
   input  wire logic        osc_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   output logic [13:0]      dac_out,
   output logic             led_green_out,
   output logic             led_red_out,
   output logic             ref_out_en_out
);
   import gfll_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic pps_rise;
   logic osc_rise;

   // The pulse rising edge is the timing instant.
   gfll_edge_sync u_pps_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .async_in   (pps_in),
      .rise_out   (pps_rise) // RULE17
   );

   // Oscillator edges sampled on the system clock.
   gfll_edge_sync u_osc_sync (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .async_in   (osc_in),
      .rise_out   (osc_rise)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   gfll_state_t state_reg;
   gfll_state_t state_next;
   logic [31:0] lock_lim_reg;
   logic [31:0] hold_lim_reg;
   logic [15:0] hcnt_lim_reg;
   logic [7:0]  avg_cnt_reg;
   logic        inhibit_reg;
   logic [13:0] dac_reg;
   logic [13:0] dac_next;
   logic        alarm_reg;
   logic [31:0] edge_cnt_reg;
   logic [4:0]  pulse_cnt_reg;
   logic        meas_run_reg;
   logic [31:0] freq_reg;
   logic [39:0] acc_reg;
   logic [7:0]  acc_n_reg;
   logic [4:0]  settle_reg;
   logic [15:0] hcnt_reg;
   logic [15:0] adj_reg;
   logic [15:0] events_reg;
   logic [31:0] loss_cnt_reg;
   logic [31:0] flash_cnt_reg;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   wire wr_ctrl  = wr_in && (addr_in == ADDR_CTRL);
   wire cmd_dis  = wr_ctrl && wdata_in[CMD_DISABLE_BIT];
   wire cmd_en   = wr_ctrl && wdata_in[CMD_ENABLE_BIT];
   wire cmd_aclr = wr_ctrl && wdata_in[CMD_ACLR_BIT];
   wire cmd_tune = wr_in && (addr_in == ADDR_TUNE);
   wire enabled  = (state_reg != ST_DISABLED);
   wire settling = (settle_reg != 5'h00);

   // Sample completes on the sixteenth pulse of a running window.
   wire sample_done = meas_run_reg && pps_rise &&
                      (pulse_cnt_reg == 5'(WINDOW_PULSES - 1)); // RULE1 RULE19
   wire [31:0] sample_val = edge_cnt_reg + {31'h0, osc_rise};

   // Absolute deviations of the sample and of the average.
   wire [31:0] dev_smp = (sample_val >= NOMINAL_COUNT) ?
                         sample_val - NOMINAL_COUNT :
                         NOMINAL_COUNT - sample_val; // RULE21
   wire [39:0] acc_sum = acc_reg + {8'h00, sample_val};
   wire [7:0]  acc_n1  = acc_n_reg + 8'h01;
   wire        avg_done = (acc_n1 >= avg_cnt_reg);
   wire [31:0] avg_val = (avg_cnt_reg == 8'h00) ? sample_val :
                         32'(acc_sum / {32'h0, avg_cnt_reg});
   wire signed [32:0] avg_err = $signed({1'b0, avg_val}) -
                                $signed({1'b0, NOMINAL_COUNT});
   wire [31:0] dev_avg = avg_err[32] ? 32'(-avg_err) : avg_err[31:0]; // RULE21
   wire smp_in_lock = dev_smp < lock_lim_reg;
   wire smp_in_hold = dev_smp <= hold_lim_reg;
   wire avg_in_lock = dev_avg < lock_lim_reg;

   // Frequency low raises DAC, clamped at the range ends.
   wire signed [15:0] step = avg_err[32] ? 16'sh0001 : 16'shffff;
   wire dac_at_top = (dac_reg == 14'h3fff);
   wire dac_at_bot = (dac_reg == 14'h0000);
   wire need_adj = (dev_avg != 32'h0) &&
                   !(avg_err[32] && dac_at_top) && !(!avg_err[32] && dac_at_bot);

   // Accepted sample finishing an averaging cycle in a tuning state.
   wire tune_state = (state_reg == ST_UNLOCKED) || (state_reg == ST_LOCKED);
   wire take_avg = sample_done && smp_in_hold && !settling && avg_done && tune_state;

   // ----------------------------------------------------------------
   // Measurement window
   // ----------------------------------------------------------------
   // Counts oscillator edges over a whole window, windows back to back.
   // The edge count runs on through the inner pulses and restarts only at window start.
   wire win_start = pps_rise && (!meas_run_reg || sample_done);
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || !enabled) begin
         meas_run_reg  <= 1'b0;
         pulse_cnt_reg <= 5'h00;
         edge_cnt_reg  <= 32'h0;
      end else begin
         meas_run_reg  <= meas_run_reg | pps_rise; // RULE1
         pulse_cnt_reg <= win_start ? 5'h00 : pulse_cnt_reg + {4'h0, pps_rise};
         edge_cnt_reg  <= win_start ? 32'h0 : sample_val; // RULE19
      end
   end

   // ----------------------------------------------------------------
   // Averaging and settling
   // ----------------------------------------------------------------
   // Out-of-limit samples are dropped; settling counts pulses.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || !enabled) begin
         acc_reg    <= 40'h0;
         acc_n_reg  <= 8'h00;
         settle_reg <= 5'h00;
      end else if (take_avg) begin
         acc_reg    <= 40'h0;
         acc_n_reg  <= 8'h00;
         settle_reg <= need_adj ? 5'(SETTLE_S) : 5'h00; // RULE4
      end else if (settling) begin
         if (pps_rise) settle_reg <= settle_reg - 5'h01; // RULE4
      end else if (sample_done && smp_in_hold && tune_state) begin
         acc_reg   <= acc_sum; // RULE2
         acc_n_reg <= acc_n1; // RULE3
      end
   end

   // ----------------------------------------------------------------
   // DAC value
   // ----------------------------------------------------------------
   // Automatic steps only in tuning states; manual load when disabled.
   always_comb begin
      dac_next = dac_reg;
      if ((state_reg == ST_DISABLED) && cmd_tune) dac_next = wdata_in[13:0]; // RULE11
      else if (take_avg && need_adj) dac_next = 14'($signed({2'b00, dac_reg}) + step); // RULE3
   end

   // Holdover keeps dac_reg untouched; disabled changes it only by a tune load.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dac_reg <= RST_DAC;
      end else begin
         dac_reg <= dac_next; // RULE8 RULE10
      end
   end

   // ----------------------------------------------------------------
   // Loop state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_UNLOCKED: if (take_avg && avg_in_lock) state_next = ST_LOCKED; // RULE5
         ST_LOCKED:   if (sample_done && !smp_in_hold) state_next = ST_HOLDOVER; // RULE7
         ST_HOLDOVER: if (sample_done && smp_in_lock) state_next = ST_LOCKED; // RULE6
                      else if (hcnt_reg >= hcnt_lim_reg) state_next = ST_UNLOCKED; // RULE9
         ST_DISABLED: if (cmd_en) state_next = ST_UNLOCKED; // RULE12
         default:     state_next = ST_UNLOCKED;
      endcase
      if (cmd_dis) state_next = ST_DISABLED; // RULE10
   end

   // State, holdover counter and event counter.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state_reg  <= ST_UNLOCKED;
         hcnt_reg   <= 16'h0;
         events_reg <= 16'h0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) events_reg <= events_reg + 16'h1;
         if (state_reg != ST_HOLDOVER) hcnt_reg <= 16'h0; // RULE22
         else if (pps_rise && (hcnt_reg != 16'hffff)) hcnt_reg <= hcnt_reg + 16'h1; // RULE9
      end
   end

   // ----------------------------------------------------------------
   // Alarm latch and reported values
   // ----------------------------------------------------------------
   // A lost pulse train raises the alarm as well as stopping the flashes.
   wire pps_lost = (loss_cnt_reg >= 32'(PPS_LOSS_CYC));
   wire alarm_evt = (sample_done && !smp_in_hold && enabled) ||
                    (state_next == ST_UNLOCKED && state_reg != ST_UNLOCKED) ||
                    (pps_lost && enabled);

   // Set wins over the clear command.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         alarm_reg <= 1'b0;
         freq_reg  <= 32'h0;
         adj_reg   <= 16'h0;
      end else begin
         alarm_reg <= alarm_evt | (alarm_reg & ~cmd_aclr); // RULE14
         if (sample_done) freq_reg <= sample_val; // RULE18
         if (take_avg && need_adj) adj_reg <= step; // RULE18
      end
   end

   // ----------------------------------------------------------------
   // Pulse watchdog and LED
   // ----------------------------------------------------------------
   // Loss timer and flash timer restart on each pulse.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         loss_cnt_reg  <= 32'(PPS_LOSS_CYC);
         flash_cnt_reg <= 32'h0;
      end else if (pps_rise) begin
         loss_cnt_reg  <= 32'h0;
         flash_cnt_reg <= 32'(FLASH_CYC); // RULE15
      end else begin
         if (!pps_lost) loss_cnt_reg <= loss_cnt_reg + 32'h1;
         if (flash_cnt_reg != 32'h0) flash_cnt_reg <= flash_cnt_reg - 32'h1;
      end
   end

   wire flashing = (flash_cnt_reg != 32'h0) && !pps_lost; // RULE15
   wire steady_g = (state_reg == ST_LOCKED) || (state_reg == ST_HOLDOVER); // RULE13
   wire steady_r = (state_reg != ST_LOCKED); // RULE13
   wire flash_red = alarm_reg && steady_g; // RULE14 RULE16
   wire led_g = flashing ? (flash_red ? 1'b0 : 1'b0) : steady_g;
   wire led_r = flashing ? flash_red : steady_r; // RULE16

   // LED and output-enable flip-flops.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         led_green_out  <= 1'b0;
         led_red_out    <= 1'b1;
         ref_out_en_out <= 1'b1;
         inhibit_reg    <= 1'b0;
      end else begin
         led_green_out  <= led_g;
         led_red_out    <= led_r;
         ref_out_en_out <= !(inhibit_reg && state_next == ST_UNLOCKED); // RULE20
         if (wr_ctrl) inhibit_reg <= wdata_in[CMD_INHIBIT_BIT];
      end
   end
   assign dac_out = dac_reg;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   // Parameter writes.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         lock_lim_reg <= RST_LOCK_LIM;
         hold_lim_reg <= RST_HOLD_LIM;
         hcnt_lim_reg <= RST_HCNT_LIM;
         avg_cnt_reg  <= RST_AVG_CNT;
      end else if (wr_in) begin
         if (addr_in == ADDR_LOCK_LIM) lock_lim_reg <= wdata_in;
         if (addr_in == ADDR_HOLD_LIM) hold_lim_reg <= wdata_in;
         if (addr_in == ADDR_HCNT_LIM) hcnt_lim_reg <= wdata_in[15:0];
         if (addr_in == ADDR_AVG_CNT)  avg_cnt_reg  <= wdata_in[7:0];
      end
   end

   // Read multiplexer, zero for unmapped addresses.
   logic [31:0] rd_mux;
   always_comb begin
      case (addr_in)
         ADDR_CTRL:     rd_mux = {28'h0, inhibit_reg, 3'h0};
         ADDR_LOCK_LIM: rd_mux = lock_lim_reg;
         ADDR_HOLD_LIM: rd_mux = hold_lim_reg;
         ADDR_HCNT_LIM: rd_mux = {16'h0, hcnt_lim_reg};
         ADDR_AVG_CNT:  rd_mux = {24'h0, avg_cnt_reg};
         ADDR_STATUS:   rd_mux = {16'h0, hcnt_reg[12:0], alarm_reg, state_reg}; // RULE18
         ADDR_FREQ:     rd_mux = freq_reg;
         ADDR_ADJ:      rd_mux = {16'h0, adj_reg};
         ADDR_EVENTS:   rd_mux = {16'h0, events_reg};
         ADDR_DAC:      rd_mux = {18'h0, dac_reg};
         default:       rd_mux = 32'h0;
      endcase
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         rdata_out <= 32'h0;
      end else begin
         rdata_out <= rd_in ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_DIS_CMD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE10
      cmd_dis |=> state_reg == ST_DISABLED) else $error("Disable command ignored.");
   AST_EN_CMD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE12
      (state_reg == ST_DISABLED && cmd_en && !cmd_dis) |=> state_reg == ST_UNLOCKED)
      else $error("Enable did not give unlocked.");
   AST_TUNE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE11
      (state_reg == ST_DISABLED && cmd_tune) |=> dac_out == $past(wdata_in[13:0]))
      else $error("Tune value not loaded.");
   AST_HOLD_DAC: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE8
      (state_reg == ST_HOLDOVER && $past(state_reg == ST_HOLDOVER)) |-> $stable(dac_reg))
      else $error("DAC moved in holdover.");
   AST_LOCK_TO_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE7
      (state_reg == ST_LOCKED && sample_done && !smp_in_hold && !cmd_dis)
      |=> state_reg == ST_HOLDOVER) else $error("Missed holdover entry.");
   AST_HCNT_CLR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE22
      (state_reg == ST_HOLDOVER && $past(state_reg) != ST_HOLDOVER) |-> hcnt_reg == 16'h0)
      else $error("Holdover counter not cleared.");
   AST_ALARM_STICKY: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE14
      (alarm_reg && !cmd_aclr) |=> alarm_reg) else $error("Alarm latch lost.");
   AST_SETTLE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE4
      (take_avg && need_adj && !cmd_dis) |=> settle_reg == 5'(SETTLE_S))
      else $error("Settling not started.");
   AST_NO_FLASH: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // RULE15
      pps_lost |=> {led_red_out, led_green_out} == $past({steady_r, steady_g}))
      else $error("Flash without pulses.");
endmodule : gfll_ctrl

// ---- rtl/gfll_edge_sync.sv ----
// Two-stage synchroniser with rising-edge pulse for an external pin.
`timescale 1ns/100ps
module gfll_edge_sync (
   input  wire logic ref_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic async_in,
   output logic      rise_out
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // First stage feeds only the second; edge taken from later stages.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Pulse on the synchronised rising edge.
   assign rise_out = sync_reg & ~last_reg;
endmodule : gfll_edge_sync

// ---- rtl/gfll_pkg.sv ----
// Package of constants and types for the GPS frequency-locked loop controller.
package gfll_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_LOCK_LIM = 4'h1;
   localparam logic [3:0] ADDR_HOLD_LIM = 4'h2;
   localparam logic [3:0] ADDR_HCNT_LIM = 4'h3;
   localparam logic [3:0] ADDR_AVG_CNT  = 4'h4;
   localparam logic [3:0] ADDR_TUNE     = 4'h5;
   localparam logic [3:0] ADDR_STATUS   = 4'h6;
   localparam logic [3:0] ADDR_FREQ     = 4'h7;
   localparam logic [3:0] ADDR_ADJ      = 4'h8;
   localparam logic [3:0] ADDR_EVENTS   = 4'h9;
   localparam logic [3:0] ADDR_DAC      = 4'ha;
   // ----------------------------------------------------------------
   // Control register bits (write one to act; the inhibit bit holds the value written)
   // ----------------------------------------------------------------
   localparam int CMD_DISABLE_BIT = 0;
   localparam int CMD_ENABLE_BIT  = 1;
   localparam int CMD_ACLR_BIT    = 2;
   localparam int CMD_INHIBIT_BIT = 3;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_LOCK_LIM = 32'h0000_0004;
   localparam logic [31:0] RST_HOLD_LIM = 32'h0000_0010;
   localparam logic [15:0] RST_HCNT_LIM = 16'h0040;
   localparam logic [7:0]  RST_AVG_CNT  = 8'h04;
   localparam logic [13:0] RST_DAC      = 14'h2000;
   // ----------------------------------------------------------------
   // Timing and measurement
   // ----------------------------------------------------------------
   localparam int          WINDOW_PULSES = 16;
   localparam int          SETTLE_S      = 16;
   localparam logic [31:0] NOMINAL_COUNT = 32'd160000000;
   localparam int          CLK_HZ        = 25000000;
   localparam int          PPS_LOSS_S    = 2;
   localparam int          PPS_LOSS_CYC  = CLK_HZ * PPS_LOSS_S;
   localparam int          FLASH_MS      = 100;
   localparam int          FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
   // ----------------------------------------------------------------
   // Loop states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_UNLOCKED,
      ST_LOCKED,
      ST_HOLDOVER,
      ST_DISABLED
   } gfll_state_t;
endpackage : gfll_pkg

// ---- tb/gfll_gps_osc_model.sv ----
// Behavioural model of the GPS pulse source and a free-running oscillator.
`timescale 1ns/100ps
module gfll_gps_osc_model #(
   parameter int PPS_PERIOD_NS = 2576,
   parameter int OSC_HALF_NS   = 88
) (
   input  wire logic run_in,
   output logic      pps_out,
   output logic      osc_out
);
   // Pulse train whose rising edge marks each second; it stays low while stopped.
   initial begin
      pps_out = 1'b0;
      forever begin
         #(PPS_PERIOD_NS / 2);
         pps_out = run_in;
         #(PPS_PERIOD_NS / 2);
         pps_out = 1'b0;
      end
   end
   // The oscillator runs free, off the sampling clock's rising edges to avoid races.
   initial begin
      osc_out = 1'b0;
      forever #(OSC_HALF_NS) osc_out = ~osc_out;
   end
endmodule : gfll_gps_osc_model

// ---- tb/tb_gfll_ctrl.sv ----
// Self-checking testbench for the frequency-locked loop controller.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_gfll_ctrl;
   import gfll_pkg::*;
   logic        ref_clk_in, sys_rst_in, wr_in, rd_in, run, pps, osc;
   logic        led_green_out, led_red_out, ref_out_en_out;
   logic [3:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, rd_val;
   logic [13:0] dac_out, dac_keep;
   int          n_fail, comparisons, cycles;

   gfll_ctrl i_gfll_ctrl (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .pps_in(pps),
      .osc_in(osc), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .dac_out(dac_out), .led_green_out(led_green_out),
      .led_red_out(led_red_out), .ref_out_en_out(ref_out_en_out));
   gfll_gps_osc_model i_gfll_gps_osc_model (.run_in(run), .pps_out(pps), .osc_out(osc));

   // Clock at 25 MHz.
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   // Cycle ceiling that cuts a hang short.
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles > 80000) begin
         n_fail++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      wr_in    <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in   <= 1'b0;
      #1 rd_val = rdata_out;
   endtask : reg_rd
   task automatic wait_state(input gfll_state_t st);
      for (int k = 0; k < 4000; k++) begin
         reg_rd(ADDR_STATUS);
         if (rd_val[1:0] === st) break;
      end
   endtask : wait_state

   task automatic t_reset();
      reg_rd(ADDR_LOCK_LIM); `CHK(rd_val, RST_LOCK_LIM)
      reg_rd(ADDR_HOLD_LIM); `CHK(rd_val, RST_HOLD_LIM)
      reg_rd(ADDR_HCNT_LIM); `CHK(rd_val[15:0], RST_HCNT_LIM)
      reg_rd(ADDR_AVG_CNT); `CHK(rd_val[7:0], RST_AVG_CNT)
      reg_wr(ADDR_DAC, 32'h0000_0000);
      reg_rd(ADDR_DAC); `CHK(rd_val[13:0], RST_DAC)
      reg_rd(4'hf); `CHK(rd_val, 32'h0000_0000)
      // No pulse has been seen since reset, so the loss alarm is already latched.
      reg_rd(ADDR_STATUS); `CHK(rd_val[2:0], 3'h4)
      `CHK({led_red_out, led_green_out}, 2'h2)
   endtask : t_reset
   task automatic t_manual();
      reg_wr(ADDR_CTRL, 32'h0000_0001);
      reg_rd(ADDR_STATUS); `CHK(rd_val[1:0], ST_DISABLED)
      `CHK({led_red_out, led_green_out}, 2'h2)
      reg_wr(ADDR_TUNE, 32'h0000_1234);
      reg_rd(ADDR_DAC); `CHK(dac_out, 14'h1234)
      reg_wr(ADDR_CTRL, 32'h0000_000a);
      reg_rd(ADDR_STATUS); `CHK(rd_val[1:0], ST_UNLOCKED)
      `CHK(ref_out_en_out, 1'b0)
      reg_wr(ADDR_TUNE, 32'h0000_0777);
      reg_wr(ADDR_CTRL, 32'h0000_0000);
      reg_rd(ADDR_DAC); `CHK(dac_out, 14'h1234)
      `CHK(ref_out_en_out, 1'b1)
   endtask : t_manual
   // Wide limits and one-sample averaging let the short windows lock.
   task automatic t_lock();
      reg_wr(ADDR_LOCK_LIM, 32'hffff_ffff);
      reg_wr(ADDR_HOLD_LIM, 32'hffff_ffff);
      reg_wr(ADDR_AVG_CNT, 32'h0000_0001);
      run <= 1'b1;
      wait_state(ST_LOCKED); `CHK(rd_val[1:0], ST_LOCKED)
      reg_rd(ADDR_ADJ); `CHK(rd_val[15:0], 16'h0001)
      // Sixteen 2576 ns pulses over a 176 ns oscillator give about 234 edges.
      reg_rd(ADDR_FREQ); `CHK(rd_val > 32'd232 && rd_val < 32'd237, 1'b1)
      `CHK(dac_out, 14'h1235)
      reg_wr(ADDR_CTRL, 32'h0000_0004);
      reg_rd(ADDR_STATUS); `CHK(rd_val[2], 1'b0)
      `CHK({led_red_out, led_green_out}, 2'h0)
      repeat (1500) @(posedge ref_clk_in);
      `CHK(dac_out, 14'h1235)
      repeat (800) @(posedge ref_clk_in);
      `CHK(dac_out, 14'h1236)
   endtask : t_lock
   task automatic t_holdover();
      reg_wr(ADDR_LOCK_LIM, 32'h0000_0000);
      reg_wr(ADDR_HOLD_LIM, 32'h0000_0000);
      wait_state(ST_HOLDOVER); `CHK(rd_val[1:0], ST_HOLDOVER)
      `CHK(rd_val[15:3] < 13'h0040, 1'b1)
      dac_keep = dac_out;
      `CHK({led_red_out, led_green_out}, 2'h2)
      repeat (1500) @(posedge ref_clk_in);
      `CHK(dac_out, dac_keep)
      reg_wr(ADDR_LOCK_LIM, 32'hffff_ffff);
      wait_state(ST_LOCKED); `CHK(rd_val[2:0], 3'h5)
      reg_wr(ADDR_HCNT_LIM, 32'h0000_0008);
      reg_wr(ADDR_LOCK_LIM, 32'h0000_0000);
      wait_state(ST_HOLDOVER); `CHK(rd_val[15:3] < 13'h0008, 1'b1)
      wait_state(ST_UNLOCKED); `CHK(rd_val[2:0], 3'h4)
      `CHK({led_red_out, led_green_out}, 2'h0)
      reg_wr(ADDR_HOLD_LIM, 32'hffff_ffff);
      reg_wr(ADDR_CTRL, 32'h0000_0004);
      reg_rd(ADDR_STATUS); `CHK(rd_val[2], 1'b0)
   endtask : t_holdover
   task automatic t_disable();
      reg_wr(ADDR_LOCK_LIM, 32'hffff_ffff);
      reg_wr(ADDR_CTRL, 32'h0000_0003);
      reg_rd(ADDR_STATUS); `CHK(rd_val[1:0], ST_DISABLED)
      dac_keep = dac_out;
      repeat (2500) @(posedge ref_clk_in);
      `CHK(dac_out, dac_keep)
   endtask : t_disable

   // Main sequence: reset for six cycles, then each scenario in turn.
   initial begin
      n_fail      = 0;
      comparisons = 0;
      cycles      = 0;
      sys_rst_in  = 1'b1;
      wr_in       = 1'b0;
      rd_in       = 1'b0;
      run         = 1'b0;
      addr_in     = 4'h0;
      wdata_in    = 32'h0000_0000;
      repeat (6) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_manual();
      t_lock();
      t_holdover();
      t_disable();
      give_verdict();
   end
endmodule : tb_gfll_ctrl
